//--- rtl/mie_consts.vh
`ifndef MIE_CONSTS_VH
`define MIE_CONSTS_VH
// ==========================================
// Instruction word fields
`define F_OP_HI 15
`define F_OP_LO 10
`define F_D_HI  9
`define F_D_LO  5
`define F_R_HI  4
`define F_R_LO  0
// ==========================================
// Opcodes
`define OP_NOP         6'h00
`define OP_BR_IRQ_ON   6'h01
`define OP_BR_IRQ_OFF  6'h02
`define OP_MOVE        6'h03
`define OP_PAIR_COPY   6'h04
`define OP_IMM         6'h05
`define OP_LOAD_PTR    6'h06
`define OP_LOAD_OFS    6'h07
`define OP_LOAD_DIR    6'h08
`define OP_STORE_PTR   6'h09
`define OP_STORE_OFS   6'h0A
`define OP_STORE_DIR   6'h0B
`define OP_PMEM_READ   6'h0C
`define OP_PUSH        6'h0D
`define OP_POP         6'h0E
`define OP_IO_SET      6'h0F
`define OP_IO_CLEAR    6'h10
`define OP_SHIFT_L     6'h11
`define OP_SHIFT_R     6'h12
`define OP_ROT_L       6'h13
`define OP_ROT_R       6'h14
`define OP_ASHIFT_R    6'h15
`define OP_NIBBLE_SWAP 6'h16
`define OP_BIT_TO_T    6'h17
`define OP_T_TO_BIT    6'h18
`define OP_FLAG_SET    6'h19
`define OP_FLAG_CLEAR  6'h1A
`define OP_SLEEP       6'h1B
`define OP_WDOG        6'h1C
`define OP_BREAK       6'h1D
// Dedicated flag opcodes: 2'b10, clear bit, flag index
`define OP_FLAG_GROUP  2'h2
// ==========================================
// Pointer pairs and addressing modes
`define PTR_X       5'h1A
`define PTR_Y       5'h1C
`define PTR_Z       5'h1E
`define PM_PLAIN    2'h0
`define PM_POST_INC 2'h1
`define PM_PRE_DEC  2'h2
// ==========================================
// Status bit positions
`define SB_C 0
`define SB_Z 1
`define SB_N 2
`define SB_V 3
`define SB_S 4
`define SB_H 5
`define SB_T 6
`define SB_I 7
// ==========================================
// Register port map and reset values
`define RA_GPR_LAST 6'h1F
`define RA_STATUS   6'h20
`define RA_PC_LO    6'h21
`define RA_PC_HI    6'h22
`define RA_SP_LO    6'h23
`define RA_SP_HI    6'h24
`define STATUS_RST  8'h00
`define PC_RST      16'h0000
`define SP_RST      16'h00FF
`define GPR_RST     8'h00
`endif

//--- rtl/mie_addr_unit.v
`timescale 1ns/1ps
`default_nettype none
`include "mie_consts.vh"
// ==========================================
// Effective address and pointer update
module mie_addr_unit (
    input  wire [15:0] i_ptr,
    input  wire [1:0]  i_mode,
    input  wire [5:0]  i_ofs,
    output wire [15:0] o_addr,
    output wire [15:0] o_ptr_next
);
    wire [15:0] dec_ptr = i_ptr - 16'h0001;
    wire [15:0] inc_ptr = i_ptr + 16'h0001;

    // Pre-decrement uses the lowered pointer for the access itself
    assign o_addr = (i_mode == `PM_PRE_DEC) ? dec_ptr
                  : i_ptr + {10'h000, i_ofs};
    assign o_ptr_next = (i_mode == `PM_POST_INC) ? inc_ptr
                      : (i_mode == `PM_PRE_DEC) ? dec_ptr : i_ptr;
endmodule // mie_addr_unit
`default_nettype wire

//--- rtl/mie_shift_unit.v
`timescale 1ns/1ps
`default_nettype none
`include "mie_consts.vh"
// ==========================================
// Shift, rotate and nibble swap
module mie_shift_unit (
    input  wire [5:0] i_op,
    input  wire [7:0] i_val,
    input  wire       i_carry,
    output reg  [7:0] o_res,
    output reg        o_carry,
    output wire       o_zero,
    output wire       o_neg,
    output wire       o_ovf
);
    always @* begin
        o_res = i_val;
        o_carry = i_carry;
        case (i_op)
            `OP_SHIFT_L: begin
                o_res = {i_val[6:0], 1'b0};
                o_carry = i_val[7];
            end
            `OP_SHIFT_R: begin
                o_res = {1'b0, i_val[7:1]};
                o_carry = i_val[0];
            end
            `OP_ROT_L: begin
                o_res = {i_val[6:0], i_carry};
                o_carry = i_val[7];
            end
            `OP_ROT_R: begin
                o_res = {i_carry, i_val[7:1]};
                o_carry = i_val[0];
            end
            `OP_ASHIFT_R: begin
                o_res = {i_val[7], i_val[7:1]};
                o_carry = i_val[0];
            end
            `OP_NIBBLE_SWAP: begin
                o_res = {i_val[3:0], i_val[7:4]};
            end
            default: begin
                o_res = i_val;
            end
        endcase
    end

    assign o_zero = (o_res == 8'h00);
    assign o_neg  = o_res[7];
    assign o_ovf  = o_res[7] ^ o_carry;
endmodule // mie_shift_unit
`default_nettype wire

//--- rtl/mie_core.v
// Behaviour
// - Interrupt-flag branch to PC+k+1; one cycle untaken, two taken.
// - Pointer load, two cycles; post-increment or pre-decrement.
// - Offset load from Y or Z plus q, two cycles; pointer kept.
// - Direct load from instruction address, two cycles.
// - Pointer store, two cycles; post-increment or pre-decrement.
// - Offset store to Y or Z plus q, two cycles; pointer kept.
// - Direct store to instruction address, two cycles.
// - Program read at Z, three cycles; R0 or named register; post-increment.
// - Push and pop, two cycles each.
// - I/O bit set or clear, two cycles; status untouched.
// - Rotates through carry, one cycle; update Z, C, N, V.
// - Arithmetic right shift keeps bit seven; one cycle; Z, C, N, V.
// - Nibble swap, one cycle, no status change.
// - Bit to T and T to bit, one cycle each.
// - Flag set or clear by index or dedicated opcode, one cycle.
// - Sleep and watchdog restart, one cycle; other units act.
// - Break acts only through the debug system.
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "mie_consts.vh"
module mie_core (
    input  wire        i_ref_clk,
    input  wire        i_rst_b,
    input  wire        i_instr_valid,
    input  wire [15:0] i_instr,
    input  wire [15:0] i_ext,
    output reg         o_instr_ready,
    output reg  [15:0] o_pc,
    output reg  [7:0]  o_status,
    output reg  [15:0] o_dmem_addr,
    output reg  [7:0]  o_dmem_wdata,
    output reg         o_dmem_we,
    output reg         o_dmem_re,
    input  wire [7:0]  i_dmem_rdata,
    output reg  [15:0] o_pmem_addr,
    output reg         o_pmem_re,
    input  wire [7:0]  i_pmem_rdata,
    output reg  [4:0]  o_io_addr,
    output reg  [2:0]  o_io_bit,
    output reg         o_io_val,
    output reg         o_io_we,
    output reg         o_sleep_req,
    output reg         o_wdog_req,
    output reg         o_break_req,
    input  wire        i_dbg_enable,
    input  wire        i_dbg_resume,
    input  wire [5:0]  i_reg_addr,
    input  wire [7:0]  i_reg_wdata,
    input  wire        i_reg_wr,
    input  wire        i_reg_rd,
    output reg  [7:0]  o_reg_rdata
);
    // ==========================================
    // State
    localparam [3:0] S_RUN   = 4'b0001;
    localparam [3:0] S_HOLD  = 4'b0010;
    localparam [3:0] S_HOLD2 = 4'b0100;
    localparam [3:0] S_BRK   = 4'b1000;

    reg [7:0]  gpr [0:31];
    reg [15:0] sp;
    reg [3:0]  state;
    reg        ld_wait;
    reg        wb_pend;
    reg        wb_pm;
    reg [4:0]  wb_idx;
    reg [7:0]  reg_rd_val;
    integer    k;

    // Load data lands as the next instruction may be taken,
    // so instruction operand reads bypass it; register port reads do not.
    wire [7:0] wb_data = wb_pm ? i_pmem_rdata : i_dmem_rdata;

    function [7:0] rd_gpr;
        input [4:0] idx;
        begin
            if (wb_pend && (wb_idx == idx)) begin
                rd_gpr = wb_data;
            end else begin
                rd_gpr = gpr[idx];
            end
        end
    endfunction

    // ==========================================
    // Decode
    wire       take = i_instr_valid & o_instr_ready;
    wire [5:0] op   = i_instr[`F_OP_HI:`F_OP_LO];
    wire [4:0] fd   = i_instr[`F_D_HI:`F_D_LO];
    wire [4:0] fr   = i_instr[`F_R_HI:`F_R_LO];
    wire [7:0] vd   = rd_gpr(fd);
    wire [7:0] vr   = rd_gpr(fr);

    wire is_ofs  = (op == `OP_LOAD_OFS) | (op == `OP_STORE_OFS);
    wire is_ptr  = (op == `OP_LOAD_PTR) | (op == `OP_STORE_PTR);
    wire is_dir  = (op == `OP_LOAD_DIR) | (op == `OP_STORE_DIR);
    wire is_push = (op == `OP_PUSH);
    wire is_pop  = (op == `OP_POP);
    wire is_ld   = (op == `OP_LOAD_PTR) | (op == `OP_LOAD_OFS)
                 | (op == `OP_LOAD_DIR) | is_pop;
    wire is_st   = (op == `OP_STORE_PTR) | (op == `OP_STORE_OFS)
                 | (op == `OP_STORE_DIR) | is_push;
    wire is_pm   = (op == `OP_PMEM_READ);
    wire is_io   = (op == `OP_IO_SET) | (op == `OP_IO_CLEAR);
    wire is_shf  = (op == `OP_SHIFT_L) | (op == `OP_SHIFT_R)
                 | (op == `OP_ROT_L) | (op == `OP_ROT_R)
                 | (op == `OP_ASHIFT_R);

    // Pointer pair: offset forms use Y or Z, program reads use Z
    reg [4:0] ptr_idx;
    always @* begin
        if (is_ofs) begin
            ptr_idx = fr[0] ? `PTR_Z : `PTR_Y;
        end else if (is_pm) begin
            ptr_idx = `PTR_Z;
        end else if (fr[1:0] == 2'h0) begin
            ptr_idx = `PTR_X;
        end else if (fr[1:0] == 2'h1) begin
            ptr_idx = `PTR_Y;
        end else begin
            ptr_idx = `PTR_Z;
        end
    end

    wire [15:0] ptr_val = {rd_gpr(ptr_idx | 5'h01), rd_gpr(ptr_idx)};
    wire [1:0]  ptr_mode = is_ptr ? fr[3:2]
                         : (is_pm && fr[0]) ? `PM_POST_INC : `PM_PLAIN;
    wire [5:0]  ptr_ofs  = is_ofs ? i_ext[5:0] : 6'h00;
    wire [15:0] ea;
    wire [15:0] ptr_next;

    mie_addr_unit u_addr (
        .i_ptr      (ptr_val),
        .i_mode     (ptr_mode),
        .i_ofs      (ptr_ofs),
        .o_addr     (ea),
        .o_ptr_next (ptr_next)
    );

    // Stack grows down: push writes at SP, pop reads at SP+1
    wire [15:0] sp_inc = sp + 16'h0001;
    wire [15:0] mem_addr = is_dir ? i_ext
                         : is_push ? sp
                         : is_pop ? sp_inc : ea;

    wire [7:0] sh_res;
    wire       sh_c;
    wire       sh_z;
    wire       sh_n;
    wire       sh_v;

    mie_shift_unit u_shift (
        .i_op    (op),
        .i_val   (vd),
        .i_carry (o_status[`SB_C]),
        .o_res   (sh_res),
        .o_carry (sh_c),
        .o_zero  (sh_z),
        .o_neg   (sh_n),
        .o_ovf   (sh_v)
    );

    // Branch offset is a signed 7-bit word count
    wire [15:0] br_ofs = {{9{i_ext[6]}}, i_ext[6:0]};
    wire        irq_on = o_status[`SB_I];
    wire        br_take = ((op == `OP_BR_IRQ_ON) & irq_on)
                        | ((op == `OP_BR_IRQ_OFF) & ~irq_on);
    wire [7:0]  bit_mask = 8'h01 << fr[2:0];
    wire [7:0]  t_bit_val = o_status[`SB_T] ? (vd | bit_mask)
                          : (vd & ~bit_mask);

    // ==========================================
    // Register port read decode
    always @* begin
        if (i_reg_addr <= `RA_GPR_LAST) begin
            reg_rd_val = gpr[i_reg_addr[4:0]];
        end else if (i_reg_addr == `RA_STATUS) begin
            reg_rd_val = o_status;
        end else if (i_reg_addr == `RA_PC_LO) begin
            reg_rd_val = o_pc[7:0];
        end else if (i_reg_addr == `RA_PC_HI) begin
            reg_rd_val = o_pc[15:8];
        end else if (i_reg_addr == `RA_SP_LO) begin
            reg_rd_val = sp[7:0];
        end else if (i_reg_addr == `RA_SP_HI) begin
            reg_rd_val = sp[15:8];
        end else begin
            reg_rd_val = 8'h00;
        end
    end

    // ==========================================
    // Execution
    // Later assignments win: core updates override a software write
    // to the same register in the same cycle.
    always @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (k = 0; k < 32; k = k + 1) begin
                gpr[k] <= `GPR_RST;
            end
            sp <= `SP_RST;
            state <= S_RUN;
            ld_wait <= 1'b0;
            wb_pend <= 1'b0;
            wb_pm <= 1'b0;
            wb_idx <= 5'h00;
            o_instr_ready <= 1'b1;
            o_pc <= `PC_RST;
            o_status <= `STATUS_RST;
            o_dmem_addr <= 16'h0000;
            o_dmem_wdata <= 8'h00;
            o_dmem_we <= 1'b0;
            o_dmem_re <= 1'b0;
            o_pmem_addr <= 16'h0000;
            o_pmem_re <= 1'b0;
            o_io_addr <= 5'h00;
            o_io_bit <= 3'h0;
            o_io_val <= 1'b0;
            o_io_we <= 1'b0;
            o_sleep_req <= 1'b0;
            o_wdog_req <= 1'b0;
            o_break_req <= 1'b0;
            o_reg_rdata <= 8'h00;
        end else begin
            o_dmem_we <= 1'b0;
            o_dmem_re <= 1'b0;
            o_pmem_re <= 1'b0;
            o_io_we <= 1'b0;
            o_sleep_req <= 1'b0;
            o_wdog_req <= 1'b0;
            o_break_req <= 1'b0;
            wb_pend <= 1'b0;
            o_reg_rdata <= i_reg_rd ? reg_rd_val : 8'h00;

            if (i_reg_wr) begin
                if (i_reg_addr <= `RA_GPR_LAST) begin
                    gpr[i_reg_addr[4:0]] <= i_reg_wdata;
                end else if (i_reg_addr == `RA_STATUS) begin
                    o_status <= i_reg_wdata;
                end else if (i_reg_addr == `RA_PC_LO) begin
                    o_pc[7:0] <= i_reg_wdata;
                end else if (i_reg_addr == `RA_PC_HI) begin
                    o_pc[15:8] <= i_reg_wdata;
                end else if (i_reg_addr == `RA_SP_LO) begin
                    sp[7:0] <= i_reg_wdata;
                end else if (i_reg_addr == `RA_SP_HI) begin
                    sp[15:8] <= i_reg_wdata;
                end
            end

            if (wb_pend) begin
                gpr[wb_idx] <= wb_data;
            end

            case (state)
                S_RUN: begin
                    if (take) begin
                        o_pc <= o_pc + 16'h0001;
                        if (br_take) begin
                            o_pc <= o_pc + br_ofs + 16'h0001;
                            o_instr_ready <= 1'b0;
                            state <= S_HOLD;
                        end
                        if (op == `OP_MOVE) begin
                            gpr[fd] <= vr;
                        end
                        if (op == `OP_PAIR_COPY) begin
                            gpr[fd & 5'h1E] <= rd_gpr(fr & 5'h1E);
                            gpr[fd | 5'h01] <= rd_gpr(fr | 5'h01);
                        end
                        if (op == `OP_IMM) begin
                            gpr[fd] <= i_ext[7:0];
                        end
                        if (is_ld | is_st) begin
                            o_dmem_addr <= mem_addr;
                            o_dmem_re <= is_ld;
                            o_dmem_we <= is_st;
                            o_dmem_wdata <= vd;
                            wb_idx <= fd;
                            wb_pm <= 1'b0;
                            ld_wait <= is_ld;
                            o_instr_ready <= 1'b0;
                            state <= S_HOLD;
                        end
                        if (is_push) begin
                            sp <= sp - 16'h0001;
                        end
                        if (is_pop) begin
                            sp <= sp_inc;
                        end
                        if (is_ptr | is_pm) begin
                            gpr[ptr_idx] <= ptr_next[7:0];
                            gpr[ptr_idx | 5'h01] <= ptr_next[15:8];
                        end
                        if (is_pm) begin
                            // Address now, strobe next cycle, data on the third
                            o_pmem_addr <= ptr_val;
                            wb_idx <= fr[1] ? fd : 5'h00;
                            wb_pm <= 1'b1;
                            ld_wait <= 1'b1;
                            o_instr_ready <= 1'b0;
                            state <= S_HOLD2;
                        end
                        if (is_io) begin
                            // Single bit write; the I/O side applies it
                            o_io_addr <= i_ext[4:0];
                            o_io_bit <= fr[2:0];
                            o_io_val <= (op == `OP_IO_SET);
                            o_io_we <= 1'b1;
                            o_instr_ready <= 1'b0;
                            state <= S_HOLD;
                        end
                        if (is_shf) begin
                            gpr[fd] <= sh_res;
                            o_status[`SB_C] <= sh_c;
                            o_status[`SB_Z] <= sh_z;
                            o_status[`SB_N] <= sh_n;
                            o_status[`SB_V] <= sh_v;
                        end
                        if (op == `OP_NIBBLE_SWAP) begin
                            gpr[fd] <= sh_res;
                        end
                        if (op == `OP_BIT_TO_T) begin
                            o_status[`SB_T] <= vd[fr[2:0]];
                        end
                        if (op == `OP_T_TO_BIT) begin
                            gpr[fd] <= t_bit_val;
                        end
                        if (op == `OP_FLAG_SET) begin
                            o_status[fr[2:0]] <= 1'b1;
                        end
                        if (op == `OP_FLAG_CLEAR) begin
                            o_status[fr[2:0]] <= 1'b0;
                        end
                        if (op[5:4] == `OP_FLAG_GROUP) begin
                            o_status[op[2:0]] <= ~op[3];
                        end
                        if (op == `OP_SLEEP) begin
                            o_sleep_req <= 1'b1;
                        end
                        if (op == `OP_WDOG) begin
                            o_wdog_req <= 1'b1;
                        end
                        if (op == `OP_BREAK) begin
                            // No debug: a one-cycle no-op
                            o_break_req <= 1'b1;
                            if (i_dbg_enable) begin
                                o_instr_ready <= 1'b0;
                                state <= S_BRK;
                            end
                        end
                    end
                end
                S_HOLD: begin
                    wb_pend <= ld_wait;
                    ld_wait <= 1'b0;
                    o_instr_ready <= 1'b1;
                    state <= S_RUN;
                end
                S_HOLD2: begin
                    o_pmem_re <= 1'b1;
                    state <= S_HOLD;
                end
                S_BRK: begin
                    if (i_dbg_resume) begin
                        o_instr_ready <= 1'b1;
                        state <= S_RUN;
                    end
                end
                default: begin
                    o_instr_ready <= 1'b1;
                    state <= S_RUN;
                end
            endcase
        end
    end
endmodule // mie_core
`default_nettype wire

//--- tb/mie_core_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "mie_consts.vh"
module mie_core_chk (
    input wire logic        i_ref_clk,
    input wire logic        i_rst_b,
    input wire logic        i_instr_valid,
    input wire logic [15:0] i_instr,
    input wire logic [15:0] i_ext,
    input wire logic        o_instr_ready,
    input wire logic [15:0] o_pc,
    input wire logic [7:0]  o_status,
    input wire logic [15:0] o_dmem_addr,
    input wire logic        o_dmem_we,
    input wire logic        o_dmem_re,
    input wire logic        o_pmem_re,
    input wire logic        o_io_we,
    input wire logic        o_sleep_req,
    input wire logic        o_wdog_req
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    wire        tk  = i_instr_valid & o_instr_ready;
    wire [5:0]  op  = i_instr[15:10];
    wire [15:0] tgt = o_pc + {{9{i_ext[6]}}, i_ext[6:0]} + 16'h0001;
    sequence s_two;
        !o_instr_ready ##1 o_instr_ready;
    endsequence
    sequence s_three;
        !o_instr_ready ##1 (!o_instr_ready && o_pmem_re) ##1 o_instr_ready;
    endsequence
    a_store_direct: assert property (tk && op == `OP_STORE_DIR |=>
        o_dmem_we && o_dmem_addr == $past(i_ext) ##0 s_two) else $error("direct store");
    a_load_direct: assert property (tk && op == `OP_LOAD_DIR |=>
        o_dmem_re && o_dmem_addr == $past(i_ext) ##0 s_two) else $error("direct load");
    a_pmem_three: assert property (tk && op == `OP_PMEM_READ |=> s_three)
        else $error("program read timing");
    a_io_bit_flags: assert property (tk && (op == `OP_IO_SET || op == `OP_IO_CLEAR) |=>
        o_io_we && o_status == $past(o_status) ##0 s_two) else $error("io bit op");
    a_branch_taken: assert property (tk && op == `OP_BR_IRQ_ON && o_status[`SB_I] |=>
        o_pc == $past(tgt) ##0 s_two) else $error("taken branch");
    a_branch_skip: assert property (tk && op == `OP_BR_IRQ_OFF && o_status[`SB_I] |=>
        o_instr_ready && o_pc == $past(o_pc) + 16'h0001) else $error("untaken branch");
    a_flag_set: assert property (tk && op == `OP_FLAG_SET |=>
        o_status == ($past(o_status) | (8'h01 << $past(i_instr[2:0])))) else $error("flag set");
    a_sleep_pulse: assert property (tk && op == `OP_SLEEP |=>
        o_sleep_req && o_instr_ready ##1 !o_sleep_req) else $error("sleep");
    a_wdog_pulse: assert property (tk && op == `OP_WDOG |=>
        o_wdog_req && o_instr_ready ##1 !o_wdog_req) else $error("watchdog restart");
endmodule // mie_core_chk
bind mie_core mie_core_chk mie_core_chk_i (.*);
`default_nettype wire

//--- tb/mie_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module mie_mem_model (
    input  wire logic        i_clk,
    input  wire logic [15:0] i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_we,
    input  wire logic        i_re,
    output logic      [7:0]  o_rdata,
    input  wire logic [15:0] i_paddr,
    input  wire logic        i_pre,
    output logic      [7:0]  o_prdata,
    input  wire logic [4:0]  i_io_addr,
    input  wire logic [2:0]  i_io_bit,
    input  wire logic        i_io_val,
    input  wire logic        i_io_we
);
    logic [7:0] dmem [0:255];
    logic [7:0] io   [0:31];
    initial o_rdata = 8'h00;
    initial o_prdata = 8'h00;
    // Read data stand one cycle, then scramble
    always @(posedge i_clk) begin
        if (i_we)
            dmem[i_addr[7:0]] <= i_wdata;
        if (i_io_we)
            io[i_io_addr][i_io_bit] <= i_io_val;
        o_rdata <= i_re ? dmem[i_addr[7:0]] : ~o_rdata;
        o_prdata <= i_pre ? (i_paddr[7:0] ^ 8'h5A) : ~o_prdata;
    end
endmodule // mie_mem_model
`default_nettype wire

//--- tb/mie_core_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "mie_consts.vh"
module mie_core_test;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        vld = 1'b0;
    logic        dbg = 1'b0;
    logic        res = 1'b0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [15:0] ins = 16'h0000;
    logic [15:0] ext = 16'h0000;
    logic [5:0]  ra = 6'h00;
    logic [7:0]  rw = 8'h00;
    logic [7:0]  e = 8'h00;
    wire  [15:0] pc, da, pa;
    wire  [7:0]  st, dwd, drd, prd, rdo;
    wire  [4:0]  ia;
    wire  [2:0]  ib;
    wire         rdy, dwe, dre, pre, iwe, iv;
    int          error_cnt = 0, n_compared = 0, cyc = 0, n;
    logic [5:0]  sop [6] = '{`OP_SHIFT_L, `OP_SHIFT_R, `OP_ROT_L, `OP_ROT_R, `OP_ASHIFT_R,
                             `OP_NIBBLE_SWAP};
    logic [7:0]  sres [6] = '{8'h02, 8'h40, 8'h03, 8'hC0, 8'hC0, 8'h18};
    logic [7:0]  sst [6] = '{8'h09, 8'h09, 8'h09, 8'h05, 8'h05, 8'h01};
    mie_core mie_core_i (.i_ref_clk(clk), .i_rst_b(rst_b), .i_instr_valid(vld), .i_instr(ins),
        .i_ext(ext), .o_instr_ready(rdy), .o_pc(pc), .o_status(st), .o_dmem_addr(da),
        .o_dmem_wdata(dwd), .o_dmem_we(dwe), .o_dmem_re(dre), .i_dmem_rdata(drd),
        .o_pmem_addr(pa), .o_pmem_re(pre), .i_pmem_rdata(prd), .o_io_addr(ia), .o_io_bit(ib),
        .o_io_val(iv), .o_io_we(iwe), .o_sleep_req(), .o_wdog_req(), .o_break_req(),
        .i_dbg_enable(dbg), .i_dbg_resume(res), .i_reg_addr(ra), .i_reg_wdata(rw),
        .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdo));
    mie_mem_model mie_mem_model_i (.i_clk(clk), .i_addr(da), .i_wdata(dwd), .i_we(dwe),
        .i_re(dre), .o_rdata(drd), .i_paddr(pa), .i_pre(pre), .o_prdata(prd),
        .i_io_addr(ia), .i_io_bit(ib), .i_io_val(iv), .i_io_we(iwe));
    always #4 clk = ~clk;
    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            error_cnt++;
            finish_test;
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        {ra, rw, wr} <= {a, d, 1'b1};
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [5:0] a, input logic [7:0] x);
        @(posedge clk);
        {ra, rd} <= {a, 1'b1};
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdo, x);
    endtask
    // Counting edges to ready checks the cycle cost
    task automatic ex(input logic [5:0] o, input int c, input logic [4:0] d = 5'h0,
                      input logic [4:0] r = 5'h0, input logic [15:0] x = 16'h0);
        @(posedge clk);
        {vld, ins, ext} <= {1'b1, o, d, r, x};
        @(posedge clk);
        vld <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rdy !== 1'b1 && n < 20);
        chk(16'(n), 16'(c));
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        rreg(6'h3F, 8'h00);
        ex(`OP_IMM, 1, 5'h10, 5'h0, 16'h81);
        ex(`OP_MOVE, 1, 5'h11, 5'h10);
        ex(`OP_PAIR_COPY, 1, 5'h02, 5'h10);
        rreg(6'h03, 8'h81);
        rreg(`RA_STATUS, 8'h00);
        ex(`OP_STORE_DIR, 2, 5'h10, 5'h0, 16'h40);
        chk(mie_mem_model_i.dmem[8'h40], 8'h81);
        ex(`OP_LOAD_DIR, 2, 5'h05, 5'h0, 16'h40);
        rreg(6'h05, 8'h81);
        wreg(6'h1E, 8'h50);
        ex(`OP_STORE_PTR, 2, 5'h10, 5'h06);
        chk(mie_mem_model_i.dmem[8'h50], 8'h81);
        rreg(6'h1E, 8'h51);
        ex(`OP_LOAD_PTR, 2, 5'h06, 5'h0A);
        rreg(6'h06, 8'h81);
        rreg(6'h1E, 8'h50);
        wreg(6'h1C, 8'h60);
        ex(`OP_STORE_OFS, 2, 5'h10, 5'h0, 16'h5);
        chk(mie_mem_model_i.dmem[8'h65], 8'h81);
        ex(`OP_LOAD_OFS, 2, 5'h07, 5'h0, 16'h5);
        rreg(6'h07, 8'h81);
        rreg(6'h1C, 8'h60);
        ex(`OP_PMEM_READ, 3, 5'h08, 5'h03);
        rreg(6'h08, 8'h0A);
        ex(`OP_PMEM_READ, 3, 5'h09);
        rreg(6'h00, 8'h0B);
        ex(`OP_PUSH, 2, 5'h10);
        chk(mie_mem_model_i.dmem[8'hFF], 8'h81);
        ex(`OP_POP, 2, 5'h0C);
        rreg(6'h0C, 8'h81);
        rreg(`RA_SP_LO, 8'hFF);
        ex(`OP_IO_SET, 2, 5'h0, 5'h05, 16'h3);
        chk(mie_mem_model_i.io[3][5], 1'b1);
        ex(`OP_IO_CLEAR, 2, 5'h0, 5'h05, 16'h3);
        chk(mie_mem_model_i.io[3][5], 1'b0);
        $display("memory tests over");
        for (int i = 0; i < 6; i++) begin
            wreg(6'h10, 8'h81);
            wreg(`RA_STATUS, 8'h01);
            ex(sop[i], 1, 5'h10);
            rreg(6'h10, sres[i]);
            rreg(`RA_STATUS, sst[i]);
        end
        ex(`OP_BIT_TO_T, 1, 5'h10, 5'h04);
        ex(`OP_T_TO_BIT, 1, 5'h0A, 5'h03);
        rreg(6'h0A, 8'h08);
        rreg(`RA_STATUS, 8'h41);
        wreg(`RA_STATUS, 8'h00);
        for (int i = 0; i < 16; i++) begin
            e = (i < 8) ? (e | (8'h01 << i)) : (e & ~(8'h01 << (i - 8)));
            ex((i < 8) ? `OP_FLAG_SET : `OP_FLAG_CLEAR, 1, 5'h0, 5'(i % 8));
            rreg(`RA_STATUS, e);
        end
        ex({`OP_FLAG_GROUP, 1'b0, 3'h1}, 1);
        chk(st, 8'h02);
        ex({`OP_FLAG_GROUP, 1'b1, 3'h1}, 1);
        chk(st, 8'h00);
        wreg(`RA_PC_HI, 8'h01);
        wreg(`RA_PC_LO, 8'h00);
        ex(`OP_BR_IRQ_OFF, 2, 5'h0, 5'h0, 16'h5);
        chk(pc, 16'h0106);
        ex(`OP_BR_IRQ_ON, 1, 5'h0, 5'h0, 16'h5);
        ex(`OP_BR_IRQ_OFF, 2, 5'h0, 5'h0, 16'h7E);
        chk(pc, 16'h0106);
        ex(`OP_FLAG_SET, 1, 5'h0, 5'h07);
        ex(`OP_BR_IRQ_ON, 2, 5'h0, 5'h0, 16'h2);
        ex(`OP_BR_IRQ_OFF, 1, 5'h0, 5'h0, 16'h2);
        chk(pc, 16'h010B);
        ex(`OP_SLEEP, 1);
        ex(`OP_WDOG, 1);
        ex(`OP_BREAK, 1);
        dbg <= 1'b1;
        fork
            begin
                repeat (6) @(posedge clk);
                res <= 1'b1;
                @(posedge clk);
                res <= 1'b0;
            end
        join_none
        ex(`OP_BREAK, 6);
        $display("control tests over");
        finish_test;
    end
endmodule // mie_core_test
`default_nettype wire
